// *** verilog/pbs_params.svh ***
// Purpose: Constants for the pipelined burst synchronous SRAM port.
// Assumes: Included by bare name by pbs_pkg only; design files use its macros without including it.
// Notes: Widths cover both organisations; narrow mode uses lanes 0..1.
//
// Overview of operation
// - Every synchronous pin is registered on the rising clock edge.
// - Address and chip selects load only when a valid address strobe is seen.
// - Later burst addresses are made internally, stepped by the advance input.
// - A two-bit counter on the low address bits covers four locations.
// - Burst order is selectable: linear or interleaved.
// - Bursts run first word in three cycles, then one cycle per word.
// - Writes register address, data and controls, then self-time the write.
// - Unless global write is low, each byte lane is written only when its own lane select asks.
// - Global write low writes every lane regardless of lane controls.
// - After deselect the drivers stay on one extra clock.
// - Read data passes an output register before reaching the pins.
// - Output enable gates the data drivers without clock sampling.
// - Processor and controller strobes each may start an access.
// - Organisation is 1M words of 36 or 2M words of 18 bits.
// - Chip selects allow several devices side by side without wait states.
// - With both strobes asserted and the pipelined select low only the processor strobe acts.
// - Chip selects are sampled only on address loads, ignored in bursts.
// - First clock of a read out of deselect keeps drivers off.
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

`define PBS_ADDR_W 21
`define PBS_ROW_W 20
`define PBS_LANES 4
`define PBS_LANE_DATA_W 8
`define PBS_BURST_W 2

`define PBS_ADDR_RST 21'h00_0000
`define PBS_CNT_RST 2'h0
`define PBS_CNT_STEP 2'h1
`define PBS_LANES_NONE 4'h0
`define PBS_LANES_ALL 4'hf
`define PBS_DQ_RST 32'h0000_0000
`define PBS_PAR_RST 4'h0

`endif

// *** verilog/pbs_pkg.sv ***
// Purpose: Types shared by the SRAM port design files.
// Assumes: pbs_params.svh supplies the widths.
// Notes: A lane is one data byte plus its parity bit.
package pbs_pkg;
`include "pbs_params.svh"

    typedef logic [`PBS_ADDR_W-1:0] pbs_addr_t;
    typedef logic [`PBS_ROW_W-1:0] pbs_row_t;
    typedef logic [`PBS_LANES-1:0] pbs_lane_mask_t;

    typedef struct packed
    {
        logic parity;
        logic [`PBS_LANE_DATA_W-1:0] data;
    } pbs_lane_s;

    typedef pbs_lane_s [`PBS_LANES-1:0] pbs_word_t;

    typedef struct packed
    {
        pbs_addr_t addr;
        pbs_word_t word;
        logic proc_n;
        logic ctrl_n;
        logic adv_n;
        logic ce1_n;
        logic ce2;
        logic ce3_n;
        logic gw_n;
        logic bwe_n;
        pbs_lane_mask_t sel_n;
        logic linear;
    } pbs_pins_s;

endpackage

// *** verilog/pbs_lane.sv ***
// Purpose: One byte lane of the array with its parity bit.
// Assumes: Write enable and row are stable before the clock edge.
// Notes: Read is combinational; the caller registers it.
`timescale 1ns/10ps
module pbs_lane
    import pbs_pkg::*;
#(
    parameter int ROW_W = `PBS_ROW_W
)
(
    input wire logic i_ref_clk,
    input wire logic i_we,
    input wire logic [ROW_W-1:0] i_row,
    input wire pbs_lane_s i_wdata,
    output pbs_lane_s o_rdata
);

    pbs_lane_s mem_q [2**ROW_W];

    // Data and parity share one enable
    always_ff @(posedge i_ref_clk)
    begin
        if (i_we)
        begin
            mem_q[i_row] <= i_wdata;
        end
    end

    assign o_rdata = mem_q[i_row];

endmodule

// *** verilog/pbs_sram_port.sv ***
// Purpose: Device side of a pipelined double-cycle-deselect burst SRAM.
// Assumes: Pins are synchronous to i_ref_clk; output enable is async.
// Notes: P_NARROW selects 2M x 18 on lanes 0..1, else 1M x 36.
`timescale 1ns/10ps
module pbs_sram_port
    import pbs_pkg::*;
#(
    parameter bit P_NARROW = 1'b0
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [`PBS_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_dq,
    input wire logic [3:0] i_parity_lane,
    input wire logic i_proc_addr_strobe_n,
    input wire logic i_ctrl_addr_strobe_n,
    input wire logic i_burst_advance_n,
    input wire logic i_pipeline_chip_sel_n,
    input wire logic i_expand_chip_sel_hi,
    input wire logic i_expand_chip_sel_n,
    input wire logic i_all_lanes_write_n,
    input wire logic i_lane_write_enable_n,
    input wire logic [3:0] i_lane_select_n,
    input wire logic i_burst_order_linear,
    input wire logic i_output_enable_n,
    output logic [31:0] o_dq,
    output logic [3:0] o_parity_lane,
    output logic o_dq_oe
);

    pbs_pins_s in_d;
    pbs_pins_s in_q;

    // Input register stage
    always_comb
    begin
        in_d.addr = i_addr;
        for (int i = 0; i < `PBS_LANES; i++)
        begin
            in_d.word[i].data = i_dq[i*8 +: 8];
            in_d.word[i].parity = i_parity_lane[i];
        end
        in_d.proc_n = i_proc_addr_strobe_n;
        in_d.ctrl_n = i_ctrl_addr_strobe_n;
        in_d.adv_n = i_burst_advance_n;
        in_d.ce1_n = i_pipeline_chip_sel_n;
        in_d.ce2 = i_expand_chip_sel_hi;
        in_d.ce3_n = i_expand_chip_sel_n;
        in_d.gw_n = i_all_lanes_write_n;
        in_d.bwe_n = i_lane_write_enable_n;
        in_d.sel_n = i_lane_select_n;
        in_d.linear = i_burst_order_linear;
        if (!i_rst_b)
        begin
            in_d = '0;
            in_d.proc_n = 1'b1;
            in_d.ctrl_n = 1'b1;
            in_d.adv_n = 1'b1;
            in_d.ce1_n = 1'b1;
            in_d.gw_n = 1'b1;
            in_d.bwe_n = 1'b1;
            in_d.sel_n = `PBS_LANES_ALL;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        in_q <= in_d;
    end

    // Burst address state
    pbs_addr_t base_d;
    pbs_addr_t base_q;
    logic [`PBS_BURST_W-1:0] cnt_d;
    logic [`PBS_BURST_W-1:0] cnt_q;
    logic active_d;
    logic active_q;

    logic selected;
    logic load_proc;
    logic load_ctrl;
    logic load;
    logic [`PBS_BURST_W-1:0] seq;
    pbs_addr_t cur_addr;

    always_comb
    begin
        selected = !in_q.ce1_n && in_q.ce2 && !in_q.ce3_n;
        // Processor strobe is void while the pipelined select is high
        load_proc = !in_q.proc_n && !in_q.ce1_n;
        load_ctrl = !in_q.ctrl_n && !load_proc;
        load = load_proc || load_ctrl;
        base_d = base_q;
        cnt_d = cnt_q;
        active_d = active_q;
        if (load)
        begin
            base_d = in_q.addr;
            cnt_d = `PBS_CNT_RST;
            active_d = selected;
        end
        else if (active_q && !in_q.adv_n)
        begin
            cnt_d = cnt_q + `PBS_CNT_STEP;
        end
        // Advance high with no strobe keeps cnt_d at cnt_q
        if (!i_rst_b)
        begin
            base_d = `PBS_ADDR_RST;
            cnt_d = `PBS_CNT_RST;
            active_d = 1'b0;
        end
        if (in_q.linear)
        begin
            seq = base_d[1:0] + cnt_d;
        end
        else
        begin
            seq = base_d[1:0] ^ cnt_d;
        end
        cur_addr = {base_d[`PBS_ADDR_W-1:2], seq};
    end

    always_ff @(posedge i_ref_clk)
    begin
        base_q <= base_d;
        cnt_q <= cnt_d;
        active_q <= active_d;
    end

    // Access decode and array
    logic wr;
    logic rd;
    logic first_rd;
    pbs_lane_mask_t lane_en;
    pbs_lane_mask_t lane_we;
    pbs_row_t row;
    pbs_word_t wdata;
    pbs_word_t rdata;
    pbs_word_t rword;

    always_comb
    begin
        // A processor-strobe load is never a write cycle
        wr = active_d && !load_proc && (!in_q.gw_n ||
            (!in_q.bwe_n && !(&in_q.sel_n)));
        rd = active_d && !wr;
        first_rd = rd && load && !active_q;
        if (!in_q.gw_n)
        begin
            lane_en = `PBS_LANES_ALL;
        end
        else
        begin
            lane_en = ~in_q.sel_n & {`PBS_LANES{!in_q.bwe_n}};
        end
        if (P_NARROW)
        begin
            // Halves of a wide row hold two consecutive narrow words
            row = cur_addr[`PBS_ADDR_W-1:1];
            wdata = {in_q.word[1:0], in_q.word[1:0]};
            lane_we = cur_addr[0] ? {lane_en[1:0], 2'h0}
                                  : {2'h0, lane_en[1:0]};
            rword = '0;
            rword[1:0] = cur_addr[0] ? rdata[3:2] : rdata[1:0];
        end
        else
        begin
            row = cur_addr[`PBS_ROW_W-1:0];
            wdata = in_q.word;
            lane_we = lane_en;
            rword = rdata;
        end
        if (!wr)
        begin
            lane_we = `PBS_LANES_NONE;
        end
    end

    // Writes complete at the next edge with no further strobes
    for (genvar g = 0; g < `PBS_LANES; g++)
    begin : g_lane
        pbs_lane #(
            .ROW_W(`PBS_ROW_W)
        ) u_lane (
            .i_ref_clk(i_ref_clk),
            .i_we(lane_we[g]),
            .i_row(row),
            .i_wdata(wdata[g]),
            .o_rdata(rdata[g])
        );
    end

    // Output pipeline and driver enable
    pbs_word_t out_d;
    pbs_word_t out_q;
    logic en1_d;
    logic en1_q;
    logic en2_d;
    logic en2_q;

    always_comb
    begin
        out_d = rd ? rword : out_q;
        en1_d = rd;
        en2_d = en1_q;
        if (!i_rst_b)
        begin
            out_d = '0;
            en1_d = 1'b0;
            en2_d = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        out_q <= out_d;
        en1_q <= en1_d;
        en2_q <= en2_d;
    end

    always_comb
    begin
        for (int i = 0; i < `PBS_LANES; i++)
        begin
            o_dq[i*8 +: 8] = out_q[i].data;
            o_parity_lane[i] = out_q[i].parity;
        end
    end

    // Output enable is deliberately not registered
    assign o_dq_oe = (en1_q || en2_q) && !first_rd
        && !i_output_enable_n;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_addr_load: assert property (
        load |=> base_q == $past(in_q.addr))
        else $error("address not loaded on strobe");

    a_proc_wins: assert property (
        (!in_q.proc_n && !in_q.ctrl_n && !in_q.ce1_n) |-> !wr)
        else $error("controller strobe acted beside processor strobe");

    a_burst_hold: assert property (
        (!load && in_q.adv_n) |=> $stable(cnt_q) && $stable(base_q))
        else $error("burst address moved without advance");

    a_burst_step: assert property (
        (!load && active_q && !in_q.adv_n)
        |=> cnt_q == $past(cnt_q) + `PBS_CNT_STEP)
        else $error("burst counter did not step");

    a_select_ignored: assert property (
        !load |=> active_q == $past(active_q))
        else $error("chip select sampled during burst");

    a_global_lanes: assert property (
        (wr && !in_q.gw_n && !P_NARROW) |-> lane_we == `PBS_LANES_ALL)
        else $error("global write missed a lane");

    a_read_pipe: assert property (
        rd |=> en1_q && out_q == $past(rword))
        else $error("read data not registered");

    a_dcd_extra: assert property (
        rd ##1 !rd |=> en2_q && !en1_q)
        else $error("drivers dropped without extra cycle");

    a_first_mask: assert property (
        first_rd |-> !o_dq_oe)
        else $error("drivers on at first read after deselect");

endmodule

// *** dv/pbs_host_model.sv ***
// Purpose: Bus master model that drives the SRAM port pins.
// Assumes: The bench calls drive once per cycle; pins change at negedge.
// Notes: Data lines flip on non-write cycles, as on a released bus.
`timescale 1ns/10ps
module pbs_host_model
    import pbs_pkg::*;
(
    input wire logic i_ref_clk,
    output pbs_pins_s o_pins,
    output logic o_oe_n
);
    initial
    begin
        o_pins = '1;
        o_oe_n = 1'b1;
    end

    task automatic drive(input pbs_pins_s p, input logic oe_n);
        pbs_word_t last;
        last = o_pins.word;
        @(negedge i_ref_clk);
        // A stale value would hide a missed capture
        if (p.gw_n && p.bwe_n)
            p.word = ~last;
        o_pins = p;
        o_oe_n = oe_n;
    endtask

    // Output enable moves between clocks
    task automatic set_oe(input logic oe_n);
        o_oe_n = oe_n;
    endtask
endmodule

// *** dv/pbs_sram_port_tb.sv ***
// Purpose: Self-checking bench for the SRAM port.
// Assumes: Wide organisation; data checked two edges after the command.
// Notes: The data wire is resolved here from both drivers.
`timescale 1ns/10ps
module pbs_sram_port_tb
    import pbs_pkg::*;
    ;
    logic i_ref_clk;
    logic i_rst_b;
    pbs_pins_s pins;
    pbs_pins_s p;
    logic oe_n;
    logic [31:0] dq_bus;
    logic [3:0] par_bus;
    logic [31:0] o_dq;
    logic [3:0] o_parity_lane;
    logic o_dq_oe;
    int n_mismatch;
    int compares;

    initial i_ref_clk = 1'b0;
    always #5 i_ref_clk = ~i_ref_clk;

    pbs_host_model u_host
    (
        .i_ref_clk(i_ref_clk),
        .o_pins(pins),
        .o_oe_n(oe_n)
    );

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            dq_bus[8*i+:8] = o_dq_oe ? o_dq[8*i+:8] : pins.word[i].data;
            par_bus[i] = o_dq_oe ? o_parity_lane[i] : pins.word[i].parity;
        end
    end

    pbs_sram_port #(.P_NARROW(1'b0)) u_dut
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_addr(pins.addr),
        .i_dq(dq_bus),
        .i_parity_lane(par_bus),
        .i_proc_addr_strobe_n(pins.proc_n),
        .i_ctrl_addr_strobe_n(pins.ctrl_n),
        .i_burst_advance_n(pins.adv_n),
        .i_pipeline_chip_sel_n(pins.ce1_n),
        .i_expand_chip_sel_hi(pins.ce2),
        .i_expand_chip_sel_n(pins.ce3_n),
        .i_all_lanes_write_n(pins.gw_n),
        .i_lane_write_enable_n(pins.bwe_n),
        .i_lane_select_n(pins.sel_n),
        .i_burst_order_linear(pins.linear),
        .i_output_enable_n(oe_n),
        .o_dq(o_dq),
        .o_parity_lane(o_parity_lane),
        .o_dq_oe(o_dq_oe)
    );

    function automatic pbs_pins_s idle();
        pbs_pins_s r;
        r = '1;
        r.ce1_n = 1'b0;
        r.ce3_n = 1'b0;
        r.addr = 21'h00_0000;
        return r;
    endfunction

    function automatic pbs_word_t wv(input int i);
        return pbs_word_t'(36'h3_c3c3_c300 + 36'(i));
    endfunction

    function automatic pbs_word_t seen();
        pbs_word_t w;
        for (int i = 0; i < 4; i++)
        begin
            w[i].parity = o_parity_lane[i];
            w[i].data = o_dq[8*i+:8];
        end
        return w;
    endfunction

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [20:0] a, input pbs_word_t w);
        p = idle();
        p.addr = a;
        p.ctrl_n = 1'b0;
        p.gw_n = 1'b0;
        p.word = w;
        u_host.drive(p, 1'b1);
    endtask

    task automatic rd(input logic [20:0] a);
        p = idle();
        p.addr = a;
        p.proc_n = 1'b0;
        u_host.drive(p, 1'b0);
    endtask

    task automatic t_basic();
        wr(21'h00_0040, wv(9));
        rd(21'h00_0040);
        u_host.drive(idle(), 1'b0);
        chk(seen(), 36'h0);
        u_host.drive(idle(), 1'b0);
        chk(seen(), wv(9));
        chk(36'(o_dq_oe), 36'h1);
        $display("done basic");
    endtask

    task automatic t_lanes();
        pbs_word_t e;
        pbs_word_t w2;
        w2 = wv(2);
        e = wv(1);
        e[0] = w2[0];
        e[2] = w2[2];
        wr(21'h00_0080, wv(1));
        p.gw_n = 1'b1;
        p.bwe_n = 1'b0;
        p.sel_n = 4'b1010;
        p.word = w2;
        u_host.drive(p, 1'b1);
        // Lane selects without the lane enable must not write
        p.bwe_n = 1'b1;
        p.sel_n = 4'b0000;
        u_host.drive(p, 1'b1);
        rd(21'h00_0080);
        u_host.drive(idle(), 1'b0);
        u_host.drive(idle(), 1'b0);
        chk(seen(), e);
        $display("done lanes");
    endtask

    task automatic t_burst(input logic lin);
        int n[5];
        int k;
        n = '{0, 1, 1, 2, 3};
        for (int i = 0; i < 4; i++)
            wr(21'h00_0100 + 21'(i), wv(16 + i));
        for (int j = 0; j < 7; j++)
        begin
            p = idle();
            p.linear = lin;
            p.proc_n = (j != 0);
            // Odd start so the two orders differ
            p.addr = 21'h00_0101;
            p.adv_n = (j == 0 || j == 2 || j > 4);
            p.ce2 = (j != 3);
            u_host.drive(p, 1'b0);
            if (j >= 2)
            begin
                k = lin ? (1 + n[j-2]) % 4 : 1 ^ n[j-2];
                chk(seen(), wv(16 + k));
            end
        end
        $display("done burst");
    endtask

    task automatic t_deselect();
        rd(21'h00_0100);
        p.ce2 = 1'b0;
        u_host.drive(p, 1'b0);
        u_host.drive(idle(), 1'b0);
        chk(36'(o_dq_oe), 36'h1);
        u_host.drive(idle(), 1'b0);
        chk(36'(o_dq_oe), 36'h1);
        u_host.drive(idle(), 1'b0);
        chk(36'(o_dq_oe), 36'h0);
        rd(21'h00_0101);
        u_host.drive(idle(), 1'b0);
        chk(36'(o_dq_oe), 36'h0);
        u_host.drive(idle(), 1'b0);
        chk(seen(), wv(17));
        u_host.set_oe(1'b1);
        #1 chk(36'(o_dq_oe), 36'h0);
        u_host.set_oe(1'b0);
        #1 chk(36'(o_dq_oe), 36'h1);
        $display("done deselect");
    endtask

    task automatic t_strobes();
        p = idle();
        p.addr = 21'h00_0101;
        p.proc_n = 1'b0;
        p.ctrl_n = 1'b0;
        p.gw_n = 1'b0;
        p.word = wv(7);
        u_host.drive(p, 1'b0);
        p = idle();
        p.proc_n = 1'b0;
        p.ce1_n = 1'b1;
        p.addr = 21'h00_0103;
        u_host.drive(p, 1'b0);
        u_host.drive(idle(), 1'b0);
        chk(seen(), wv(17));
        u_host.drive(idle(), 1'b0);
        chk(seen(), wv(17));
        $display("done strobes");
    endtask

    task automatic wrap_up();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (2000) @(posedge i_ref_clk);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        i_rst_b = 1'b0;
        n_mismatch = 0;
        compares = 0;
        repeat (3) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        chk(36'(o_dq_oe), 36'h0);
        chk(seen(), 36'h0);
        u_host.drive(idle(), 1'b1);
        t_basic();
        t_lanes();
        t_burst(1'b1);
        t_burst(1'b0);
        t_deselect();
        t_strobes();
        wrap_up();
    end
endmodule
